// >>> hdl/svwd_params.svh
`ifndef SVWD_PARAMS_SVH
`define SVWD_PARAMS_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define SVWD_CLK_HZ           40000000
`define SVWD_CLK_PERIOD_NS    25

// ----------------------------------------
// Timing figures in their own units
// ----------------------------------------
`define SVWD_RST_STRETCH_MS   200
`define SVWD_WD_PERIOD_MS     1560

// ----------------------------------------
// Cycle counts derived from the rate
// ----------------------------------------
`define SVWD_RST_STRETCH_CYC  ((`SVWD_CLK_HZ / 1000) * `SVWD_RST_STRETCH_MS)
`define SVWD_WD_PERIOD_CYC    ((`SVWD_CLK_HZ / 1000) * `SVWD_WD_PERIOD_MS)

// ----------------------------------------
// Synchroniser reset values, bit order of svwd_ind_t
// ----------------------------------------
`define SVWD_IND_WIDTH        7
`define SVWD_IND_RST          7'h10

`endif

// >>> hdl/svwd_pkg.sv
package svwd_pkg;

    // ----------------------------------------
    // Comparator and pin indications
    // ----------------------------------------
    typedef struct packed {
        logic supply_ok;
        logic lowline_above_hi;
        logic manual_reset_n;
        logic lowline_above_lo;
        logic lockout_ok;
        logic powerfail_above_ref;
        logic watchdog_kick_in;
    } svwd_ind_t;

    // ----------------------------------------
    // Reset sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        SVWD_HOLD    = 2'b00,
        SVWD_STRETCH = 2'b01,
        SVWD_RUN     = 2'b10
    } svwd_rst_state_t;

    // ----------------------------------------
    // Output group
    // ----------------------------------------
    typedef struct packed {
        logic reset_n;
        logic reset_out;
        logic watchdog_alarm_n;
        logic powerfail_alarm_n;
        logic low_line_n;
    } svwd_out_t;

endpackage

// >>> hdl/svwd_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module svwd_sync3 #(
    parameter int unsigned                  WIDTH    = 1,
    parameter logic [WIDTH-1:0]             RST_VAL  = '0
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic [WIDTH-1:0]           async_in,
    output logic      [WIDTH-1:0]           stable_q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] stable_d;

    // ----------------------------------------
    // Accept a bit only when stages two and three agree
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign stable_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stable_q[i];
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= RST_VAL;
            s2_q     <= RST_VAL;
            s3_q     <= RST_VAL;
            stable_q <= RST_VAL;
        end else begin
            meta_q   <= async_in;
            s2_q     <= meta_q;
            s3_q     <= s2_q;
            stable_q <= stable_d;
        end
    end

endmodule

`default_nettype wire

// >>> hdl/svwd_timer.sv
`timescale 1ns/1ps
`default_nettype none

module svwd_timer #(
    parameter int unsigned                  LIMIT = 1
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       restart,
    output logic                            done_q
);

    logic [31:0] count_q;
    logic [31:0] count_d;
    logic        hit;
    logic        done_d;

    // ----------------------------------------
    // Done rises LIMIT edges after restart drops
    // ----------------------------------------
    assign hit     = (count_q == 32'(LIMIT - 1));
    assign count_d = restart ? 32'h0000_0000 :
                     (done_q | hit) ? count_q : count_q + 32'h0000_0001;
    assign done_d  = !restart && (done_q || hit);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 32'h0000_0000;
            done_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            done_q  <= done_d;
        end
    end

endmodule

`default_nettype wire

// >>> hdl/svwd_supervisor.sv
// What this block does
// - Kick must toggle within the period; otherwise watchdog alarm goes low.
// - Supply below reset threshold holds watchdog alarm low regardless of timer.
// - Watchdog alarm has no minimum low time; rises at once when supply recovers.
// - Supply drop asserts reset in the same cycle the watchdog alarm drops.
// - Alarm wired to manual reset gives a full reset including the stretch.
// - Power-fail alarm low while sense input is below its reference.
// - Low-supply warning low under threshold 60mV above reset, 2mV hysteresis.
// - Manual reset low asserts reset, held 200ms after it returns high.
// - Manual reset reads high when open, thanks to its pull-up.
// - Bouncing switch restarts the stretch until the input stays high.
// - Below lock-out level, warning and both alarm outputs are forced low.
// - Reset held 200ms after supply recovers; a dip restarts the interval.
// - Active-high reset output is the exact complement of active-low reset.

`timescale 1ns/1ps
`default_nettype none
`include "svwd_params.svh"

module svwd_supervisor #(
    parameter int unsigned                  STRETCH_CYC = `SVWD_RST_STRETCH_CYC,
    parameter int unsigned                  WD_CYC      = `SVWD_WD_PERIOD_CYC
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       supply_ok_in,
    input  wire logic                       lowline_above_hi_in,
    input  wire logic                       lowline_above_lo_in,
    input  wire logic                       lockout_ok_in,
    input  wire logic                       powerfail_sense_in,
    input  wire logic                       manual_reset_n,
    input  wire logic                       watchdog_kick_in,
    output svwd_pkg::svwd_out_t             out_q
);

    import svwd_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    svwd_ind_t       raw_ind;
    svwd_ind_t       ind_s;
    svwd_rst_state_t state_q;
    svwd_rst_state_t state_d;
    svwd_out_t       out_d;

    logic            kick_prev_q;
    logic            kick_edge;
    logic            wd_restart;
    logic            wd_expired;
    logic            stretch_restart;
    logic            stretch_done;
    logic            rst_cause;
    logic            lock_ok;
    logic            ll_ok_q;
    logic            ll_ok_d;
    logic            run_next;

    // ----------------------------------------
    // Pin indications into the clock domain
    // ----------------------------------------
    // Open manual reset pin is pulled high outside, so a 1 here means idle
    assign raw_ind.supply_ok           = supply_ok_in;
    assign raw_ind.lowline_above_hi    = lowline_above_hi_in;
    assign raw_ind.manual_reset_n      = manual_reset_n;
    assign raw_ind.lowline_above_lo    = lowline_above_lo_in;
    assign raw_ind.lockout_ok          = lockout_ok_in;
    assign raw_ind.powerfail_above_ref = powerfail_sense_in;
    assign raw_ind.watchdog_kick_in    = watchdog_kick_in;

    svwd_sync3 #(
        .WIDTH    (`SVWD_IND_WIDTH),
        .RST_VAL  (`SVWD_IND_RST)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (raw_ind),
        .stable_q (ind_s)
    );

    // ----------------------------------------
    // Lock-out
    // ----------------------------------------
    assign lock_ok = ind_s.lockout_ok;

    // ----------------------------------------
    // Reset sequencer
    // ----------------------------------------
    // Either cause holds reset; any return of a cause restarts the stretch
    assign rst_cause = !ind_s.supply_ok || !ind_s.manual_reset_n;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SVWD_HOLD: begin
                if (!rst_cause) begin
                    state_d = SVWD_STRETCH;
                end
            end
            SVWD_STRETCH: begin
                if (rst_cause) begin
                    state_d = SVWD_HOLD;
                end else if (stretch_done) begin
                    state_d = SVWD_RUN;
                end
            end
            SVWD_RUN: begin
                if (rst_cause) begin
                    state_d = SVWD_HOLD;
                end
            end
            default: begin
                state_d = SVWD_HOLD;
            end
        endcase
    end

    // Timer held at zero outside the stretch state
    assign stretch_restart = (state_q != SVWD_STRETCH) || rst_cause;

    svwd_timer #(
        .LIMIT    (STRETCH_CYC)
    ) u_stretch (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .restart  (stretch_restart),
        .done_q   (stretch_done)
    );

    assign run_next = (state_d == SVWD_RUN);

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    // Either edge of the kick counts, so a stuck level always times out
    assign kick_edge  = ind_s.watchdog_kick_in != kick_prev_q;
    // Timer cleared while reset is out, fresh period at release
    assign wd_restart = kick_edge || !out_q.reset_n;

    svwd_timer #(
        .LIMIT    (WD_CYC)
    ) u_wd (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .restart  (wd_restart),
        .done_q   (wd_expired)
    );

    // ----------------------------------------
    // Low-line comparator with hysteresis
    // ----------------------------------------
    // Two thresholds 2mV apart stand for the hysteresis band
    assign ll_ok_d = ind_s.lowline_above_hi ||
                     (ll_ok_q && ind_s.lowline_above_lo);

    // ----------------------------------------
    // Output next values
    // ----------------------------------------
    // Alarm follows supply directly, not the stretched reset, so it
    // has no minimum low time; manual reset is left out of it so that
    // a loop from the alarm back to manual reset can release itself
    assign out_d.watchdog_alarm_n  = lock_ok && ind_s.supply_ok &&
                                     !wd_expired;
    // Reset and alarm are decided from the same sampled supply bit
    assign out_d.reset_n           = run_next;
    assign out_d.reset_out         = !run_next;
    assign out_d.powerfail_alarm_n = lock_ok && ind_s.powerfail_above_ref;
    assign out_d.low_line_n        = lock_ok && ll_ok_d;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= SVWD_HOLD;
            kick_prev_q <= 1'b0;
            ll_ok_q     <= 1'b0;
        end else begin
            state_q     <= state_d;
            kick_prev_q <= ind_s.watchdog_kick_in;
            ll_ok_q     <= ll_ok_d;
        end
    end

    // Supply-good reset leaves the host in reset with alarms low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= '{reset_n: 1'b0, reset_out: 1'b1, watchdog_alarm_n: 1'b0,
                       powerfail_alarm_n: 1'b0, low_line_n: 1'b0};
        end else begin
            out_q <= out_d;
        end
    end

endmodule

`default_nettype wire

// >>> verif/svwd_supervisor_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module svwd_supervisor_chk
    import svwd_pkg::*;
#(
    parameter int unsigned STRETCH_CYC = 20,
    parameter int unsigned WD_CYC      = 50
) (
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                supply_ok_in,
    input wire logic                lowline_above_hi_in,
    input wire logic                lowline_above_lo_in,
    input wire logic                lockout_ok_in,
    input wire logic                powerfail_sense_in,
    input wire logic                manual_reset_n,
    input wire logic                watchdog_kick_in,
    input wire svwd_pkg::svwd_out_t out_q
);
    // ----------------------------------------
    // Cycle counters since cause cleared / last kick
    // ----------------------------------------
    logic [31:0] rel_q;
    logic [31:0] wd_q;
    logic        kick_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rel_q <= '0;
            wd_q <= '0;
            kick_q <= 1'b0;
        end else begin
            rel_q <= (!supply_ok_in || !manual_reset_n) ? '0 : rel_q + 1;
            wd_q <= (watchdog_kick_in != kick_q || !out_q.reset_n) ? '0 : wd_q + 1;
            kick_q <= watchdog_kick_in;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    rst_comp_a: assert property (out_q.reset_out == !out_q.reset_n)
        else $error("reset outputs not complementary");
    sup_low_a: assert property ((!supply_ok_in)[*8] |-> !out_q.watchdog_alarm_n && !out_q.reset_n)
        else $error("supply low without reset and alarm");
    same_edge_a: assert property ($fell(out_q.reset_n) && !supply_ok_in && manual_reset_n
        && lockout_ok_in |-> !out_q.watchdog_alarm_n)
        else $error("alarm not low with supply reset");
    lock_force_a: assert property ((!lockout_ok_in)[*8] |-> out_q[2:0] == 3'b000)
        else $error("lock-out did not force outputs low");
    pfail_level_a: assert property (($stable({powerfail_sense_in, lockout_ok_in}))[*8]
        |-> out_q.powerfail_alarm_n == (powerfail_sense_in && lockout_ok_in))
        else $error("power-fail alarm level wrong");
    lowline_high_a: assert property ((lowline_above_hi_in && lockout_ok_in)[*8]
        |-> out_q.low_line_n)
        else $error("low-line warning low above threshold");
    stretch_len_a: assert property ($rose(out_q.reset_n) |-> rel_q >= STRETCH_CYC + 2
        && rel_q <= STRETCH_CYC + 9)
        else $error("reset stretch length wrong");
    wd_timeout_a: assert property ($fell(out_q.watchdog_alarm_n) && out_q.reset_n && lockout_ok_in
        && supply_ok_in |-> wd_q >= WD_CYC - 1 && wd_q <= WD_CYC + 8)
        else $error("watchdog timeout length wrong");
    wd_cleared_a: assert property ((!out_q.reset_n && supply_ok_in && lockout_ok_in)[*8]
        |-> out_q.watchdog_alarm_n)
        else $error("watchdog alarm low during reset");

    cover property ($rose(out_q.reset_n));
    cover property ($fell(out_q.watchdog_alarm_n) && out_q.reset_n);
    cover property ($fell(out_q.powerfail_alarm_n));
endmodule

`default_nettype wire

// >>> verif/svwd_host.sv
`timescale 1ns/1ps
`default_nettype none

module svwd_host #(
    parameter int unsigned KICK_CYC = 20
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic alarm_n,
    input  wire logic kick_en,
    input  wire logic loop_en,
    output logic      kick,
    output logic      man_rst_n
);
    int unsigned cnt = 0;

    initial kick = 1'b0;
    // Alarm wired back to manual reset; open pin otherwise
    assign man_rst_n = loop_en ? alarm_n : 1'b1;

    // Software only kicks while out of reset
    always @(negedge clk_sys) begin
        if (kick_en && reset_n) begin
            cnt <= (cnt + 1) % KICK_CYC;
            if (cnt == KICK_CYC - 1) kick <= !kick;
        end
    end
endmodule

`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import svwd_pkg::*;
    localparam int S = 20;
    localparam int W = 50;
    logic clk_sys, rst_n, sup, hi, lo, lock, pf_sense, kick_en, loop_en, man_drv, kick;
    logic host_man;
    svwd_out_t out_q;
    int miscompares = 0;
    int cmp_count = 0;
    int n;
    localparam logic [2:0] LL [4] = '{3'b011, 3'b000, 3'b010, 3'b111};

    svwd_supervisor #(.STRETCH_CYC(S), .WD_CYC(W)) svwd_supervisor_i (.clk_sys(clk_sys),
        .rst_n(rst_n), .supply_ok_in(sup), .lowline_above_hi_in(hi), .lowline_above_lo_in(lo),
        .lockout_ok_in(lock), .powerfail_sense_in(pf_sense), .manual_reset_n(man_drv & host_man),
        .watchdog_kick_in(kick), .out_q(out_q));
    svwd_host svwd_host_i (.clk_sys(clk_sys), .reset_n(out_q.reset_n),
        .alarm_n(out_q.watchdog_alarm_n), .kick_en(kick_en), .loop_en(loop_en), .kick(kick),
        .man_rst_n(host_man));

    always #12.5 clk_sys = ~clk_sys;

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic s, input logic e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s exp %b got %b", nm, e, s);
        end
    endtask

    // Bounded wait for one output bit
    task automatic wait_out(input int b, input logic v, output int k);
        k = 0;
        while (out_q[b] !== v) begin
            cyc(1);
            k++;
            if (k > 4000) begin
                miscompares++;
                conclude();
            end
        end
    endtask

    task automatic t_powerup();
        wait_out(4, 1'b1, n);
        chk("por_len", n >= S + 2 && n <= S + 9, 1'b1);
        chk("rst_out", out_q.reset_out, 1'b0);
    endtask

    task automatic t_kick();
        cyc(3 * W);
        chk("wd_kept", out_q.watchdog_alarm_n, 1'b1);
        kick_en = 0;
        wait_out(2, 1'b0, n);
        chk("wd_len", n >= W - 22 && n <= W + 8, 1'b1);
        kick_en = 1;
        wait_out(2, 1'b1, n);
        chk("wd_clear", n <= 30, 1'b1);
    endtask

    task automatic t_loop();
        kick_en = 0;
        loop_en = 1;
        wait_out(2, 1'b0, n);
        wait_out(4, 1'b0, n);
        chk("loop_rst", n <= 8, 1'b1);
        wait_out(2, 1'b1, n);
        chk("wd_cleared", n <= 4, 1'b1);
        kick_en = 1;
        wait_out(4, 1'b1, n);
        chk("loop_len", n >= S + 1 && n <= S + 9, 1'b1);
        loop_en = 0;
    endtask

    // Switch bounce: high gaps shorter than the stretch
    task automatic t_mr();
        repeat (3) begin
            man_drv = 0;
            cyc(6);
            man_drv = 1;
            cyc(10);
        end
        chk("bounce_hold", out_q.reset_n, 1'b0);
        wait_out(4, 1'b1, n);
        chk("man_len", n >= S - 8 && n <= S - 1, 1'b1);
    endtask

    task automatic t_supply();
        sup = 0;
        wait_out(4, 1'b0, n);
        chk("alarm_with_rst", out_q.watchdog_alarm_n, 1'b0);
        cyc(10);
        sup = 1;
        wait_out(2, 1'b1, n);
        chk("alarm_fast", n <= 6, 1'b1);
        chk("rst_still", out_q.reset_n, 1'b0);
        cyc(8);
        sup = 0;
        cyc(5);
        sup = 1;
        wait_out(4, 1'b1, n);
        chk("dip_len", n >= S + 2 && n <= S + 9, 1'b1);
    endtask

    task automatic t_levels();
        for (int v = 0; v < 2; v++) begin
            pf_sense = v[0];
            cyc(8);
            chk("pf_alarm", out_q.powerfail_alarm_n, v[0]);
        end
        // Middle band keeps the previous state
        for (int i = 0; i < 4; i++) begin
            {hi, lo} = LL[i][2:1];
            cyc(8);
            chk("low_line", out_q.low_line_n, LL[i][0]);
        end
        lock = 0;
        cyc(8);
        chk("lock", out_q[2:0] === 3'b000, 1'b1);
        lock = 1;
        cyc(8);
        chk("unlock", out_q.powerfail_alarm_n, 1'b1);
    endtask

    initial begin
        clk_sys = 0;
        rst_n = 0;
        {sup, hi, lo, lock, pf_sense, kick_en, man_drv} = 7'h7F;
        loop_en = 0;
        cyc(12);
        rst_n = 1;
        t_powerup();
        t_kick();
        t_loop();
        t_mr();
        t_supply();
        t_levels();
        conclude();
    end
endmodule

bind svwd_supervisor svwd_supervisor_chk #(.STRETCH_CYC(STRETCH_CYC), .WD_CYC(WD_CYC))
    svwd_supervisor_chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .supply_ok_in(supply_ok_in),
    .lowline_above_hi_in(lowline_above_hi_in), .lowline_above_lo_in(lowline_above_lo_in),
    .lockout_ok_in(lockout_ok_in), .powerfail_sense_in(powerfail_sense_in),
    .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in), .out_q(out_q));

`default_nettype wire
